// [hdl/cso_pkg.sv]
// shared constants and types for the configuration status outputs
package cso_pkg;

   // physical and virtual function counts
   localparam int NUM_PF = 2;
   localparam int NUM_VF = 6;

   // status field widths
   localparam int LSTAT_W   = 2;
   localparam int WIDTH_W   = 4;
   localparam int SPEED_W   = 3;
   localparam int SIZE_W    = 3;
   localparam int CMD_PER   = 4;
   localparam int PWR_PER   = 3;
   localparam int VF_PER    = 2;
   localparam int REG_W     = 16;
   localparam int PM_W      = 2;
   localparam int BYTES_W   = 13;

   // field positions inside configuration registers
   localparam int LS_SPEED_LO  = 0;
   localparam int LS_WIDTH_LO  = 4;
   localparam int DC_MPS_LO    = 5;
   localparam int DC_MRRS_LO   = 12;
   localparam int CMD_IO_BIT   = 0;
   localparam int CMD_MEM_BIT  = 1;
   localparam int CMD_BM_BIT   = 2;
   localparam int CMD_INTX_BIT = 10;

   // link state codes
   localparam logic [1:0] LSTAT_NO_RCVR  = 2'h0;
   localparam logic [1:0] LSTAT_TRAINING = 2'h1;
   localparam logic [1:0] LSTAT_DL_INIT  = 2'h2;
   localparam logic [1:0] LSTAT_DL_DONE  = 2'h3;

   // link rate codes and raw speed field values
   localparam logic [1:0] SPD_FIELD_2G5 = 2'h1;
   localparam logic [1:0] SPD_FIELD_5G  = 2'h2;
   localparam logic [1:0] SPD_FIELD_8G  = 2'h3;
   localparam logic [2:0] RATE_NONE     = 3'h0;
   localparam logic [2:0] RATE_2G5      = 3'h1;
   localparam logic [2:0] RATE_5G       = 3'h2;
   localparam logic [2:0] RATE_8G       = 3'h4;

   // power state field values and output codes
   localparam logic [1:0] PM_FIELD_D0    = 2'h0;
   localparam logic [1:0] PM_FIELD_D1    = 2'h1;
   localparam logic [1:0] PM_FIELD_D3HOT = 2'h3;
   localparam logic [2:0] PWR_D0_UNINIT  = 3'h0;
   localparam logic [2:0] PWR_D0_ACTIVE  = 3'h1;
   localparam logic [2:0] PWR_D1         = 3'h2;
   localparam logic [2:0] PWR_D3HOT      = 3'h4;

   // size limit codes
   localparam logic [2:0]         SIZE_CODE_MAX = 3'h5;
   localparam logic [BYTES_W-1:0] SIZE_BASE     = 13'h0080;

   // major training states, gray coded along the usual path
   typedef enum logic [3:0] {
      LT_DETECT   = 4'h0,
      LT_POLLING  = 4'h1,
      LT_CONFIG   = 4'h3,
      LT_L0       = 4'h2,
      LT_RECOVERY = 4'h6,
      LT_L0S      = 4'h7,
      LT_L1       = 4'h5,
      LT_L2       = 4'h4,
      LT_DISABLED = 4'hC
   } cso_ltssm_e;

endpackage

// [hdl/cso_status_dev.sv]
// core end: derives the configuration status outputs from core state
`timescale 1ns/10ps
module cso_status_dev (
   // clock and reset
   input  wire logic                                        clk,
   input  wire logic                                        rst_n,
   // training state and data link progress
   input  wire cso_pkg::cso_ltssm_e                         ltssm_state,
   input  wire logic                                        dl_init_done,
   // configuration register contents
   input  wire logic [cso_pkg::REG_W-1:0]                   link_status,
   input  wire logic [cso_pkg::REG_W-1:0]                   dev_control,
   input  wire logic [cso_pkg::NUM_PF*cso_pkg::REG_W-1:0]   func_command,
   input  wire logic [cso_pkg::NUM_PF*cso_pkg::PM_W-1:0]    func_pm_state,
   input  wire logic [cso_pkg::NUM_PF-1:0]                  func_d0_active,
   // virtual function state
   input  wire logic [cso_pkg::NUM_VF-1:0]                  vf_enabled,
   input  wire logic [cso_pkg::NUM_VF-1:0]                  vf_bus_master,
   // status towards user logic
   cso_status_if.dev                                        st
);

   typedef struct packed {
      cso_pkg::cso_ltssm_e                                  prev_state;
      logic                                                 cfg_via_polling;
      logic                                                 link_down;
      logic [cso_pkg::LSTAT_W-1:0]                          link_code;
      logic [cso_pkg::WIDTH_W-1:0]                          width;
      logic [cso_pkg::SPEED_W-1:0]                          speed;
      logic [cso_pkg::SIZE_W-1:0]                           mps;
      logic [cso_pkg::SIZE_W-1:0]                           mrrs;
      logic [cso_pkg::NUM_PF*cso_pkg::CMD_PER-1:0]          fstat;
      logic [cso_pkg::NUM_VF*cso_pkg::VF_PER-1:0]           vflags;
      logic [cso_pkg::NUM_PF*cso_pkg::PWR_PER-1:0]          fpwr;
   } cso_dev_state_s;

   cso_dev_state_s                                  state_reg;
   cso_dev_state_s                                  state_next;
   logic                                            link_up;
   logic                                            cfg_entry;
   logic                                            cfg_from_polling;
   // per-function fields built by the generate loops
   logic [cso_pkg::NUM_PF*cso_pkg::CMD_PER-1:0]     fstat_w;
   logic [cso_pkg::NUM_PF*cso_pkg::PWR_PER-1:0]     fpwr_w;
   logic [cso_pkg::NUM_VF*cso_pkg::VF_PER-1:0]      vflags_w;

   // raw speed field to one-hot rate code
   function automatic logic [cso_pkg::SPEED_W-1:0] rate_code(
      input logic [1:0] field
   );
      logic [cso_pkg::SPEED_W-1:0] code;
      case (field)
         cso_pkg::SPD_FIELD_2G5: code = cso_pkg::RATE_2G5;
         cso_pkg::SPD_FIELD_5G:  code = cso_pkg::RATE_5G;
         cso_pkg::SPD_FIELD_8G:  code = cso_pkg::RATE_8G;
         default:                code = cso_pkg::RATE_NONE;
      endcase
      return code;
   endfunction

   // power management field to output power code
   function automatic logic [cso_pkg::PWR_PER-1:0] power_code(
      input logic [cso_pkg::PM_W-1:0] pm,
      input logic                     d0_active
   );
      logic [cso_pkg::PWR_PER-1:0] code;
      case (pm)
         cso_pkg::PM_FIELD_D0: begin
            code = d0_active ? cso_pkg::PWR_D0_ACTIVE : cso_pkg::PWR_D0_UNINIT;
         end
         cso_pkg::PM_FIELD_D1:    code = cso_pkg::PWR_D1;
         cso_pkg::PM_FIELD_D3HOT: code = cso_pkg::PWR_D3HOT;
         default:                 code = cso_pkg::PWR_D0_UNINIT;
      endcase
      return code;
   endfunction

   // command register to the four enables of one function
   function automatic logic [cso_pkg::CMD_PER-1:0] cmd_bits(
      input logic [cso_pkg::REG_W-1:0] cmd
   );
      logic [cso_pkg::CMD_PER-1:0] b;
      b = {cmd[cso_pkg::CMD_INTX_BIT], cmd[cso_pkg::CMD_BM_BIT],
           cmd[cso_pkg::CMD_MEM_BIT], cmd[cso_pkg::CMD_IO_BIT]};
      return b;
   endfunction

   // configuration entry seen this cycle
   assign cfg_entry = (ltssm_state == cso_pkg::LT_CONFIG) &&
                      (state_reg.prev_state != cso_pkg::LT_CONFIG);

   // previous state polling: configuration came through detect then polling
   assign cfg_from_polling = (state_reg.prev_state == cso_pkg::LT_POLLING);

   // LinkUp state variable
   always_comb begin
      case (ltssm_state)
         cso_pkg::LT_RECOVERY,
         cso_pkg::LT_L0,
         cso_pkg::LT_L0S,
         cso_pkg::LT_L1,
         cso_pkg::LT_L2: begin
            link_up = 1'b1;
         end
         cso_pkg::LT_CONFIG: begin
            // down only when reached through detect then polling
            if (cfg_entry) begin
               link_up = !cfg_from_polling;
            end else begin
               link_up = !state_reg.cfg_via_polling;
            end
         end
         default: begin
            link_up = 1'b0;
         end
      endcase
   end

   always_comb begin
      state_next            = state_reg;
      state_next.prev_state = ltssm_state;

      // remember how configuration was reached
      if (cfg_entry) begin
         state_next.cfg_via_polling = cfg_from_polling;
      end

      state_next.link_down = !link_up;

      // link state code
      if (ltssm_state == cso_pkg::LT_DETECT) begin
         state_next.link_code = cso_pkg::LSTAT_NO_RCVR;
      end else if (!link_up) begin
         state_next.link_code = cso_pkg::LSTAT_TRAINING;
      end else if (dl_init_done) begin
         state_next.link_code = cso_pkg::LSTAT_DL_DONE;
      end else begin
         state_next.link_code = cso_pkg::LSTAT_DL_INIT;
      end

      state_next.width = link_status[cso_pkg::LS_WIDTH_LO +: cso_pkg::WIDTH_W];
      state_next.speed = rate_code(link_status[cso_pkg::LS_SPEED_LO +: 2]);
      state_next.mps   = dev_control[cso_pkg::DC_MPS_LO +: cso_pkg::SIZE_W];
      state_next.mrrs  = dev_control[cso_pkg::DC_MRRS_LO +: cso_pkg::SIZE_W];

      // per-function fields from the generate loops
      state_next.fstat  = fstat_w;
      state_next.fpwr   = fpwr_w;
      state_next.vflags = vflags_w;
   end

   // command bits and power code of each physical function
   for (genvar f = 0; f < cso_pkg::NUM_PF; f++) begin : g_pf
      // four enables of one function
      assign fstat_w[f*cso_pkg::CMD_PER +: cso_pkg::CMD_PER] =
         cmd_bits(func_command[f*cso_pkg::REG_W +: cso_pkg::REG_W]);
      // power code of one function
      assign fpwr_w[f*cso_pkg::PWR_PER +: cso_pkg::PWR_PER] =
         power_code(func_pm_state[f*cso_pkg::PM_W +: cso_pkg::PM_W],
                    func_d0_active[f]);
   end

   // enable and bus master flags of each virtual function
   for (genvar v = 0; v < cso_pkg::NUM_VF; v++) begin : g_vf
      // lower bit software enable, upper bit bus master enable
      assign vflags_w[v*cso_pkg::VF_PER]     = vf_enabled[v];
      assign vflags_w[v*cso_pkg::VF_PER + 1] = vf_bus_master[v];
   end

   // reset leaves link-down low until release
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg            <= '0;
         state_reg.prev_state <= cso_pkg::LT_DETECT;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs come straight from flip-flops
   assign st.phy_link_down          = state_reg.link_down;
   assign st.phy_link_status        = state_reg.link_code;
   assign st.negotiated_width       = state_reg.width;
   assign st.current_speed          = state_reg.speed;
   assign st.max_payload            = state_reg.mps;
   assign st.max_read_req           = state_reg.mrrs;
   assign st.function_status        = state_reg.fstat;
   assign st.virtual_function_flags = state_reg.vflags;
   assign st.function_power_state   = state_reg.fpwr;

endmodule

// [hdl/cso_status_if.sv]
// interface carrying the status outputs from core to user logic
`timescale 1ns/10ps
interface cso_status_if;
   logic                                           phy_link_down;
   logic [cso_pkg::LSTAT_W-1:0]                    phy_link_status;
   logic [cso_pkg::WIDTH_W-1:0]                    negotiated_width;
   logic [cso_pkg::SPEED_W-1:0]                    current_speed;
   logic [cso_pkg::SIZE_W-1:0]                     max_payload;
   logic [cso_pkg::SIZE_W-1:0]                     max_read_req;
   logic [cso_pkg::NUM_PF*cso_pkg::CMD_PER-1:0]    function_status;
   logic [cso_pkg::NUM_VF*cso_pkg::VF_PER-1:0]     virtual_function_flags;
   logic [cso_pkg::NUM_PF*cso_pkg::PWR_PER-1:0]    function_power_state;

   modport dev (
      output phy_link_down,
      output phy_link_status,
      output negotiated_width,
      output current_speed,
      output max_payload,
      output max_read_req,
      output function_status,
      output virtual_function_flags,
      output function_power_state
   );

   modport usr (
      input  phy_link_down,
      input  phy_link_status,
      input  negotiated_width,
      input  current_speed,
      input  max_payload,
      input  max_read_req,
      input  function_status,
      input  virtual_function_flags,
      input  function_power_state
   );
endinterface

// [hdl/cso_status_usr.sv]
// user end: turns status outputs into byte limits and link-gated lanes and permissions
`timescale 1ns/10ps
module cso_status_usr (
   // clock and reset
   input  wire logic                                 clk,
   input  wire logic                                 rst_n,
   // status from core
   cso_status_if.usr                                 st,
   // lengths the user logic intends to use, in bytes
   input  wire logic [cso_pkg::BYTES_W-1:0]          tx_payload_len,
   input  wire logic [cso_pkg::BYTES_W-1:0]          rd_req_len,
   // derived status
   output logic                                      link_ready,
   output logic [cso_pkg::WIDTH_W-1:0]               lanes,
   output logic [cso_pkg::BYTES_W-1:0]               payload_limit,
   output logic [cso_pkg::BYTES_W-1:0]               read_limit,
   output logic                                      tx_len_ok,
   output logic                                      rd_len_ok,
   output logic [cso_pkg::NUM_PF-1:0]                pf_may_request,
   output logic [cso_pkg::NUM_PF-1:0]                pf_may_complete
);

   typedef struct packed {
      logic                                          ready;
      logic [cso_pkg::WIDTH_W-1:0]                   lanes;
      logic [cso_pkg::BYTES_W-1:0]                   mps_bytes;
      logic [cso_pkg::BYTES_W-1:0]                   mrrs_bytes;
      logic                                          tx_ok;
      logic                                          rd_ok;
      logic [cso_pkg::NUM_PF-1:0]                    req;
      logic [cso_pkg::NUM_PF-1:0]                    cpl;
   } cso_usr_state_s;

   cso_usr_state_s state_reg;
   cso_usr_state_s state_next;
   logic           up;

   // size code to byte limit; reserved codes fall back to the smallest
   function automatic logic [cso_pkg::BYTES_W-1:0] size_bytes(
      input logic [cso_pkg::SIZE_W-1:0] code
   );
      logic [cso_pkg::BYTES_W-1:0] b;
      if (code > cso_pkg::SIZE_CODE_MAX) begin
         b = cso_pkg::SIZE_BASE;
      end else begin
         b = cso_pkg::SIZE_BASE << code;
      end
      return b;
   endfunction

   assign up = (st.phy_link_status == cso_pkg::LSTAT_DL_DONE) && !st.phy_link_down;

   always_comb begin
      state_next            = state_reg;
      state_next.ready      = up;
      state_next.lanes      = up ? st.negotiated_width : '0;
      state_next.mps_bytes  = size_bytes(st.max_payload);
      state_next.mrrs_bytes = size_bytes(st.max_read_req);
      state_next.tx_ok      = tx_payload_len <= size_bytes(st.max_payload);
      state_next.rd_ok      = rd_req_len <= size_bytes(st.max_read_req);
      for (int f = 0; f < cso_pkg::NUM_PF; f++) begin
         state_next.req[f] = up && st.function_status[f*cso_pkg::CMD_PER + 2];
         state_next.cpl[f] = up && (st.function_status[f*cso_pkg::CMD_PER] ||
                                    st.function_status[f*cso_pkg::CMD_PER + 1]);
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign link_ready      = state_reg.ready;
   assign lanes           = state_reg.lanes;
   assign payload_limit   = state_reg.mps_bytes;
   assign read_limit      = state_reg.mrrs_bytes;
   assign tx_len_ok       = state_reg.tx_ok;
   assign rd_len_ok       = state_reg.rd_ok;
   assign pf_may_request  = state_reg.req;
   assign pf_may_complete = state_reg.cpl;

endmodule

// [sim/config_status_outputs_bench.sv]
// self-checking bench joining both ends of the status outputs
`timescale 1ns/10ps
module config_status_outputs_bench;
   localparam logic [2:0] RATE_TAB [4] = '{3'h0, 3'h1, 3'h2, 3'h4};
   localparam logic [2:0] PW_TAB [8]   = '{3'h0, 3'h1, 3'h2, 3'h2, 3'h0, 3'h0, 3'h4, 3'h4};
   localparam int         CMD_POS [4]  = '{0, 1, 2, 10};
   logic                clk;
   logic                rst_n;
   cso_pkg::cso_ltssm_e ltssm_state;
   logic                dl_init_done;
   logic [15:0]         link_status;
   logic [15:0]         dev_control;
   logic [31:0]         func_command;
   logic [3:0]          func_pm_state;
   logic [1:0]          func_d0_active;
   logic [5:0]          vf_enabled;
   logic [5:0]          vf_bus_master;
   logic [12:0]         tx_payload_len;
   logic [12:0]         rd_req_len;
   logic                link_ready;
   logic [3:0]          lanes;
   logic [12:0]         payload_limit;
   logic [12:0]         read_limit;
   logic                tx_len_ok;
   logic                rd_len_ok;
   logic [1:0]          pf_may_request;
   logic [1:0]          pf_may_complete;
   int                  fails;
   int                  checked;

   cso_status_if st_if ();
   cso_status_dev cso_status_dev_inst (.clk, .rst_n, .ltssm_state, .dl_init_done, .link_status,
      .dev_control, .func_command, .func_pm_state, .func_d0_active, .vf_enabled,
      .vf_bus_master, .st(st_if.dev));
   cso_status_usr cso_status_usr_inst (.clk, .rst_n, .st(st_if.usr), .tx_payload_len,
      .rd_req_len, .link_ready, .lanes, .payload_limit, .read_limit, .tx_len_ok, .rd_len_ok,
      .pf_may_request, .pf_may_complete);
   cso_status_properties props_inst (.clk, .rst_n, .ltssm_state, .dl_init_done, .link_status,
      .dev_control, .func_command, .vf_enabled, .vf_bus_master, .func_pm_state, .func_d0_active,
      .phy_link_down(st_if.phy_link_down), .phy_link_status(st_if.phy_link_status),
      .negotiated_width(st_if.negotiated_width), .current_speed(st_if.current_speed),
      .max_payload(st_if.max_payload), .max_read_req(st_if.max_read_req),
      .function_status(st_if.function_status),
      .virtual_function_flags(st_if.virtual_function_flags),
      .function_power_state(st_if.function_power_state));

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      checked++;
      if (g !== e) begin
         fails++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic report_and_stop();
      if (fails == 0 && checked > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   // drive a training state and check link down and state code
   task automatic lt(input cso_pkg::cso_ltssm_e s, input logic d, input logic dn,
                     input logic [1:0] cd);
      ltssm_state = s;
      dl_init_done = d;
      cyc(1);
      chk("link_down", 16'(dn), 16'(st_if.phy_link_down));
      chk("link_status", 16'(cd), 16'(st_if.phy_link_status));
   endtask

   function automatic logic [12:0] lim(input int k);
      return (k > 5) ? 13'h0080 : 13'(13'h0080 << k);
   endfunction

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   initial begin
      fails = 0;
      checked = 0;
      rst_n = 1'b0;
      ltssm_state = cso_pkg::LT_DETECT;
      {dl_init_done, link_status, dev_control, func_command, func_pm_state, func_d0_active,
       vf_enabled, vf_bus_master, tx_payload_len, rd_req_len} = '0;
      cyc(3);
      chk("link_down", 16'h0000, 16'(st_if.phy_link_down));
      cyc(1);
      rst_n = 1'b1;
      lt(cso_pkg::LT_DETECT, 1'b0, 1'b1, 2'h0);
      lt(cso_pkg::LT_POLLING, 1'b0, 1'b1, 2'h1);
      lt(cso_pkg::LT_CONFIG, 1'b0, 1'b1, 2'h1);
      lt(cso_pkg::LT_CONFIG, 1'b0, 1'b1, 2'h1);
      lt(cso_pkg::LT_L0, 1'b0, 1'b0, 2'h2);
      lt(cso_pkg::LT_L0, 1'b1, 1'b0, 2'h3);
      lt(cso_pkg::LT_RECOVERY, 1'b0, 1'b0, 2'h2);
      lt(cso_pkg::LT_CONFIG, 1'b0, 1'b0, 2'h2);
      lt(cso_pkg::LT_L0S, 1'b1, 1'b0, 2'h3);
      lt(cso_pkg::LT_L1, 1'b1, 1'b0, 2'h3);
      lt(cso_pkg::LT_L2, 1'b1, 1'b0, 2'h3);
      lt(cso_pkg::LT_DISABLED, 1'b0, 1'b1, 2'h1);
      lt(cso_pkg::LT_L0, 1'b1, 1'b0, 2'h3);
      for (int i = 0; i < 4; i++) begin
         link_status = {8'hA5, 4'(9 + i), 2'(3 - i), 2'(i)};
         cyc(1);
         chk("speed", 16'(RATE_TAB[i]), 16'(st_if.current_speed));
         chk("width", 16'(9 + i), 16'(st_if.negotiated_width));
         cyc(1);
         chk("lanes", 16'(9 + i), 16'(lanes));
      end
      lt(cso_pkg::LT_DISABLED, 1'b0, 1'b1, 2'h1);
      cyc(1);
      chk("lanes", 16'h0000, 16'(lanes));
      chk("link_ready", 16'h0000, 16'(link_ready));
      lt(cso_pkg::LT_L0, 1'b1, 1'b0, 2'h3);
      for (int c = 0; c < 8; c++) begin
         dev_control = {1'b1, 3'(c), 4'hF, 3'(7 - c), 5'h1F};
         tx_payload_len = 13'(lim(7 - c) + 13'(c[0]));
         rd_req_len = 13'(lim(c) + 13'(!c[0]));
         cyc(1);
         chk("max_payload", 16'(7 - c), 16'(st_if.max_payload));
         chk("max_read_req", 16'(c), 16'(st_if.max_read_req));
         cyc(1);
         chk("payload_limit", 16'(lim(7 - c)), 16'(payload_limit));
         chk("read_limit", 16'(lim(c)), 16'(read_limit));
         chk("link_ready", 16'h0001, 16'(link_ready));
         chk("tx_len_ok", 16'(!c[0]), 16'(tx_len_ok));
         chk("rd_len_ok", 16'(c[0]), 16'(rd_len_ok));
      end
      for (int i = 0; i < 8; i++) begin
         func_command = 32'hFBF8_FBF8 | (32'h0000_0001 << (16 * (i / 4) + CMD_POS[i % 4]));
         cyc(1);
         chk("function_status", 16'(8'h01 << i), 16'(st_if.function_status));
         cyc(1);
         chk("may_request", 16'((i % 4 == 2) << (i / 4)), 16'(pf_may_request));
         chk("may_complete", 16'((i % 4 < 2) << (i / 4)), 16'(pf_may_complete));
      end
      for (int i = 0; i < 12; i++) begin
         vf_enabled = 6'(!i[0]) << (i / 2);
         vf_bus_master = 6'(i[0]) << (i / 2);
         cyc(1);
         chk("vf_flags", 16'(12'h001 << i), 16'(st_if.virtual_function_flags));
      end
      for (int i = 0; i < 8; i++) begin
         func_pm_state = {2'((7 - i) >> 1), 2'(i >> 1)};
         func_d0_active = {~i[0], i[0]};
         cyc(1);
         chk("power", 16'({PW_TAB[7 - i], PW_TAB[i]}), 16'(st_if.function_power_state));
      end
      lt(cso_pkg::LT_DISABLED, 1'b0, 1'b1, 2'h1);
      rst_n = 1'b0;
      cyc(1);
      chk("link_down", 16'h0000, 16'(st_if.phy_link_down));
      rst_n = 1'b1;
      cyc(1);
      chk("link_down", 16'h0001, 16'(st_if.phy_link_down));
      report_and_stop();
   end
endmodule

// [sim/cso_status_properties.sv]
// checker tying the status outputs to the core inputs one cycle earlier
`timescale 1ns/10ps
module cso_status_properties (
   // clock and reset
   input wire logic                clk,
   input wire logic                rst_n,
   // core inputs
   input wire cso_pkg::cso_ltssm_e ltssm_state,
   input wire logic                dl_init_done,
   input wire logic [15:0]         link_status,
   input wire logic [15:0]         dev_control,
   input wire logic [31:0]         func_command,
   input wire logic [5:0]          vf_enabled,
   input wire logic [5:0]          vf_bus_master,
   input wire logic [3:0]          func_pm_state,
   input wire logic [1:0]          func_d0_active,
   // status outputs
   input wire logic                phy_link_down,
   input wire logic [1:0]          phy_link_status,
   input wire logic [3:0]          negotiated_width,
   input wire logic [2:0]          current_speed,
   input wire logic [2:0]          max_payload,
   input wire logic [2:0]          max_read_req,
   input wire logic [7:0]          function_status,
   input wire logic [11:0]         virtual_function_flags,
   input wire logic [5:0]          function_power_state
);
   logic [2:0]  spd_exp;
   logic [3:0]  wid_exp;
   logic [2:0]  mps_exp;
   logic [2:0]  rrq_exp;
   logic [7:0]  cmd_exp;
   logic [11:0] vf_exp;
   logic [5:0]  pwr_exp;

   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   always_comb begin
      case (link_status[1:0])
         2'h1:    spd_exp = 3'h1;
         2'h2:    spd_exp = 3'h2;
         2'h3:    spd_exp = 3'h4;
         default: spd_exp = 3'h0;
      endcase
      wid_exp = link_status[7:4];
      mps_exp = dev_control[7:5];
      rrq_exp = dev_control[14:12];
      for (int f = 0; f < 2; f++) begin
         cmd_exp[4*f]   = func_command[16*f];
         cmd_exp[4*f+1] = func_command[16*f+1];
         cmd_exp[4*f+2] = func_command[16*f+2];
         cmd_exp[4*f+3] = func_command[16*f+10];
         case (func_pm_state[2*f +: 2])
            2'h0:    pwr_exp[3*f +: 3] = {2'h0, func_d0_active[f]};
            2'h1:    pwr_exp[3*f +: 3] = 3'h2;
            2'h3:    pwr_exp[3*f +: 3] = 3'h4;
            default: pwr_exp[3*f +: 3] = 3'h0;
         endcase
      end
      for (int v = 0; v < 6; v++) begin
         vf_exp[2*v]   = vf_enabled[v];
         vf_exp[2*v+1] = vf_bus_master[v];
      end
   end

   sequence s_poll_cfg;
      ltssm_state == cso_pkg::LT_POLLING ##1 ltssm_state == cso_pkg::LT_CONFIG;
   endsequence
   sequence s_rec_cfg;
      ltssm_state == cso_pkg::LT_RECOVERY ##1 ltssm_state == cso_pkg::LT_CONFIG;
   endsequence

   AST_RESET_LOW: assert property ($rose(rst_n) |-> !phy_link_down)
      else $error("link down not low in reset");
   AST_UP_STATES: assert property ($past(rst_n) && $past(ltssm_state) inside
      {cso_pkg::LT_L0, cso_pkg::LT_RECOVERY, cso_pkg::LT_L0S, cso_pkg::LT_L1,
       cso_pkg::LT_L2} |-> !phy_link_down)
      else $error("link down in a link up state");
   AST_CFG_POLL: assert property (s_poll_cfg |=> phy_link_down && phy_link_status == 2'h1)
      else $error("config after polling not down");
   AST_CFG_OTHER: assert property (s_rec_cfg |=> !phy_link_down)
      else $error("config after recovery down");
   AST_L0_CODE: assert property ($past(rst_n) && $past(ltssm_state) == cso_pkg::LT_L0
      |-> phy_link_status == {1'b1, $past(dl_init_done)})
      else $error("link state code wrong in L0");
   AST_WIDTH: assert property ($past(rst_n) |-> negotiated_width == $past(wid_exp))
      else $error("width wrong");
   AST_SPEED: assert property ($past(rst_n) |-> current_speed == $past(spd_exp))
      else $error("speed wrong");
   AST_PAYLOAD: assert property ($past(rst_n) |-> max_payload == $past(mps_exp))
      else $error("payload code wrong");
   AST_READ_REQ: assert property ($past(rst_n) |-> max_read_req == $past(rrq_exp))
      else $error("read request code wrong");
   AST_FUNC_CMD: assert property ($past(rst_n) |-> function_status == $past(cmd_exp))
      else $error("function status wrong");
   AST_VF_FLAGS: assert property ($past(rst_n) |-> virtual_function_flags == $past(vf_exp))
      else $error("vf flags wrong");
   AST_POWER: assert property ($past(rst_n) |-> function_power_state == $past(pwr_exp))
      else $error("power state wrong");
endmodule
